// ---- pmac_i2c_slave.sv ----
// shared package and the two-wire serial slave engine of the phase/address config block
`timescale 1ns/1ps
`default_nettype none

package pmac_pkg;
  // register bus geometry and byte offsets
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 32;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_VID      = 8'h08;
  localparam logic [7:0] OFS_BANK     = 8'h10;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;
  // control and status fields
  localparam int         CTRL_SER_EN  = 0;
  localparam logic       CTRL_SER_EN_RST = 1'h1;
  localparam int         ST_EN        = 0;
  localparam int         ST_TWO       = 1;
  localparam int         ST_MODE      = 2;
  localparam int         ST_ADDR      = 8;
  // serial register bank
  localparam int         BANK_REGS    = 8;
  localparam logic [7:0] BANK_CLEAR   = 8'h00;
  localparam int         PHASE_REG    = 2;
  localparam int         PHASE_BIT    = 6;
  localparam logic [5:0] ADDR_PREFIX  = 6'h23;
  localparam int         VID_W        = 8;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  typedef enum logic [2:0] {
    PMAC_TBL_A = 3'b001,
    PMAC_TBL_B = 3'b010,
    PMAC_TBL_C = 3'b100
  } pmac_table_t;

  typedef enum logic [6:0] {
    PMAC_SER_IDLE  = 7'b0000001,
    PMAC_SER_ADDR  = 7'b0000010,
    PMAC_SER_ACK_A = 7'b0000100,
    PMAC_SER_WDATA = 7'b0001000,
    PMAC_SER_ACK_W = 7'b0010000,
    PMAC_SER_RDATA = 7'b0100000,
    PMAC_SER_RACK  = 7'b1000000
  } pmac_ser_st_t;

  typedef struct packed {
    logic en_above;
    logic tsel_ge_lo;
    logic tsel_gt_hi;
    logic phase_limit_pin;
    logic addr_to_supply;
    logic addr_grounded;
  } pmac_pins_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] data;
  } pmac_ser_wr_t;
endpackage

module pmac_i2c_slave (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rstn_i,
  // serial bus pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  // register bank side
  input  wire logic                  enable_i,
  input  wire logic [6:0]            slave_addr_i,
  output pmac_pkg::pmac_ser_wr_t     wr_o,
  output logic [7:0]                 ptr_o,
  input  wire logic [7:0]            rd_data_i
);
  import pmac_pkg::*;

  logic [1:0]   scl_sync;
  logic [1:0]   sda_sync;
  logic         scl_q;
  logic         sda_q;
  pmac_ser_st_t state;
  logic [3:0]   cnt;
  logic [7:0]   shreg;
  logic [7:0]   tx;
  logic         first;
  logic         rw;
  logic         acked;
  logic         rise;
  logic         fall;
  logic         start;
  logic         stop;

  // clock pin is only ever sampled, never driven
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  assign rise  = scl_sync[1] & ~scl_q;
  assign fall  = ~scl_sync[1] & scl_q;
  assign start = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  // open drain: only the enable moves
  assign sda_o = 1'b0;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state    <= PMAC_SER_IDLE;
      cnt      <= 4'h0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      first    <= 1'b0;
      rw       <= 1'b0;
      acked    <= 1'b0;
      sda_oe_o <= 1'b0;
      ptr_o    <= 8'h00;
      wr_o     <= '0;
    end else begin
      wr_o.wr <= 1'b0;
      if (stop) begin
        state    <= PMAC_SER_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start) begin
        state    <= PMAC_SER_ADDR;
        cnt      <= 4'h0;
        sda_oe_o <= 1'b0;
      end else begin
        unique case (state)
          PMAC_SER_IDLE: begin
          end
          PMAC_SER_ADDR: begin
            if (rise) begin
              shreg <= {shreg[6:0], sda_sync[1]};
              cnt   <= cnt + 4'h1;
            end else if (fall && cnt == BYTE_BITS) begin
              // foreign addresses are left alone until the next start
              if (enable_i && shreg[7:1] == slave_addr_i) begin
                state    <= PMAC_SER_ACK_A;
                sda_oe_o <= 1'b1;
                rw       <= shreg[0];
              end else begin
                state <= PMAC_SER_IDLE;
              end
            end
          end
          PMAC_SER_ACK_A: begin
            if (fall) begin
              cnt <= 4'h0;
              if (rw) begin
                state    <= PMAC_SER_RDATA;
                tx       <= rd_data_i;
                sda_oe_o <= ~rd_data_i[7];
              end else begin
                state    <= PMAC_SER_WDATA;
                first    <= 1'b1;
                sda_oe_o <= 1'b0;
              end
            end
          end
          PMAC_SER_WDATA: begin
            if (rise) begin
              shreg <= {shreg[6:0], sda_sync[1]};
              cnt   <= cnt + 4'h1;
            end else if (fall && cnt == BYTE_BITS) begin
              if (first) begin
                ptr_o <= shreg;
                first <= 1'b0;
              end else begin
                wr_o.wr   <= 1'b1;
                wr_o.idx  <= ptr_o;
                wr_o.data <= shreg;
                ptr_o     <= ptr_o + 8'h01;
              end
              state    <= PMAC_SER_ACK_W;
              sda_oe_o <= 1'b1;
            end
          end
          PMAC_SER_ACK_W: begin
            if (fall) begin
              state    <= PMAC_SER_WDATA;
              cnt      <= 4'h0;
              sda_oe_o <= 1'b0;
            end
          end
          PMAC_SER_RDATA: begin
            if (rise) begin
              cnt <= cnt + 4'h1;
            end else if (fall) begin
              if (cnt == BYTE_BITS) begin
                state    <= PMAC_SER_RACK;
                sda_oe_o <= 1'b0;
                ptr_o    <= ptr_o + 8'h01;
              end else begin
                tx       <= {tx[6:0], 1'b0};
                sda_oe_o <= ~tx[6];
              end
            end
          end
          PMAC_SER_RACK: begin
            if (rise) begin
              acked <= ~sda_sync[1];
            end else if (fall) begin
              if (acked) begin
                state    <= PMAC_SER_RDATA;
                cnt      <= 4'h0;
                tx       <= rd_data_i;
                sda_oe_o <= ~rd_data_i[7];
              end else begin
                state <= PMAC_SER_IDLE;
              end
            end
          end
          default: begin
            state    <= PMAC_SER_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// ---- pmac_config.sv ----
// phase count, table select and serial address configuration with register bus
//
// Summary of operation
// - controller stays disabled while enable comparator is low, runs when high.
// - table select pin levels choose decode table A, B or C.
// - undriven identification inputs read one in tables A/B, zero in C.
// - phase-limit pin high forces single phase, ignoring the serial phase bit.
// - phase-limit pin low takes phase count from bit 6 of serial register 2.
// - phase bit default selects two-phase operation.
// - phase count changes apply live, no restart needed.
// - serial address 1000_110x with resistor to ground, 1000_111x to supply.
// - grounding the multipurpose pin clears every serial register to zero.
// - serial clock is input only, supplied by the host.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pmac_config #(
  parameter int NREGS = pmac_pkg::BANK_REGS
) (
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          rstn_i,
  // axi4-lite write address and data
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [pmac_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  input  wire logic [pmac_pkg::DATA_W-1:0]   s_axi_wdata_i,
  input  wire logic [3:0]                    s_axi_wstrb_i,
  // axi4-lite write response
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  output logic [1:0]                         s_axi_bresp_o,
  // axi4-lite read
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  input  wire logic [pmac_pkg::ADDR_W-1:0]   s_axi_araddr_i,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  output logic [pmac_pkg::DATA_W-1:0]        s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  // configuration pins, already compared to their thresholds
  input  wire pmac_pkg::pmac_pins_t          pins_i,
  input  wire logic [pmac_pkg::VID_W-1:0]    voltage_id_level_i,
  input  wire logic [pmac_pkg::VID_W-1:0]    voltage_id_driven_i,
  // serial bus
  input  wire logic                          scl_i,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe_o,
  // controller configuration outputs
  output logic                               controller_en_o,
  output pmac_pkg::pmac_table_t              table_mode_o,
  output logic [pmac_pkg::VID_W-1:0]         vid_code_o,
  output logic                               vid_pull_up_o,
  output logic                               vid_pull_down_o,
  output logic                               phase_two_o
);
  import pmac_pkg::*;

  localparam int         IDX_W      = (NREGS > 1) ? $clog2(NREGS) : 1;
  localparam logic [4:0] SEL_CTRL   = 5'h00;
  localparam logic [4:0] SEL_STATUS = 5'h01;
  localparam logic [4:0] SEL_VID    = 5'h02;
  localparam logic [4:0] SEL_BANK0  = 5'h03;
  localparam logic [4:0] SEL_NONE   = 5'h1f;

  // address decode shared by the write and the read path
  function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a - OFS_BANK;
    if (a[1:0] != 2'h0) begin
      reg_sel = SEL_NONE;
    end else if (a == OFS_CTRL) begin
      reg_sel = SEL_CTRL;
    end else if (a == OFS_STATUS) begin
      reg_sel = SEL_STATUS;
    end else if (a == OFS_VID) begin
      reg_sel = SEL_VID;
    end else if (a >= OFS_BANK && 32'(rel[ADDR_W-1:2]) < NREGS) begin
      reg_sel = SEL_BANK0 + 5'(rel[ADDR_W-1:2]);
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  logic                aw_held;
  logic                w_held;
  logic [ADDR_W-1:0]   aw_addr;
  logic [DATA_W-1:0]   w_data;
  logic [3:0]          w_strb;
  logic                wr_fire;
  logic [4:0]          wr_sel;
  logic [4:0]          rd_sel;
  logic [DATA_W-1:0]   next_rdata;
  logic [DATA_W-1:0]   status_word;
  logic                ser_en;
  logic                strap_done;
  logic                addr_lsb;
  logic [6:0]          slave_addr;
  logic [7:0]          bank [NREGS];
  pmac_ser_wr_t        ser_wr;
  logic [7:0]          ser_ptr;
  logic [7:0]          ser_rd_data;

  // axi write channel: address and data may arrive in either order
  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
  assign wr_fire         = aw_held & w_held & ~s_axi_bvalid_o;
  assign wr_sel          = reg_sel(aw_addr);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= '0;
      w_data         <= '0;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // the only writable word; status, vid and bank words are read-only views
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser_en <= CTRL_SER_EN_RST;
    end else if (wr_fire && wr_sel == SEL_CTRL && w_strb[0]) begin
      ser_en <= w_data[CTRL_SER_EN];
    end
  end

  // axi read channel
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign rd_sel          = reg_sel(s_axi_araddr_i);

  always_comb begin
    status_word                  = '0;
    status_word[ST_EN]           = controller_en_o;
    status_word[ST_TWO]          = phase_two_o;
    status_word[ST_MODE +: 3]    = table_mode_o;
    status_word[ST_ADDR +: 7]    = slave_addr;
  end

  always_comb begin
    next_rdata = '0;
    if (rd_sel == SEL_CTRL) begin
      next_rdata[CTRL_SER_EN] = ser_en;
    end else if (rd_sel == SEL_STATUS) begin
      next_rdata = status_word;
    end else if (rd_sel == SEL_VID) begin
      next_rdata[VID_W-1:0] = vid_code_o;
    end else if (rd_sel != SEL_NONE) begin
      next_rdata[7:0] = bank[IDX_W'(rd_sel - SEL_BANK0)];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= next_rdata;
      s_axi_rresp_o  <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // enable comparator gates the whole controller
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      controller_en_o <= 1'b0;
    end else begin
      controller_en_o <= pins_i.en_above;
    end
  end

  // three-level table select from two comparator outputs
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      table_mode_o <= PMAC_TBL_A;
    end else if (!pins_i.tsel_ge_lo) begin
      table_mode_o <= PMAC_TBL_A;
    end else if (pins_i.tsel_gt_hi) begin
      table_mode_o <= PMAC_TBL_C;
    end else begin
      table_mode_o <= PMAC_TBL_B;
    end
  end

  // weak pulls follow the table; an undriven input reads the pulled level
  assign vid_pull_up_o   = (table_mode_o != PMAC_TBL_C);
  assign vid_pull_down_o = (table_mode_o == PMAC_TBL_C);

  for (genvar g = 0; g < VID_W; g++) begin : g_vid
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        vid_code_o[g] <= 1'b0;
      end else begin
        vid_code_o[g] <= voltage_id_driven_i[g] ? voltage_id_level_i[g] : vid_pull_up_o;
      end
    end
  end

  // address strap caught once after reset release, not continuously
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_done <= 1'b0;
      addr_lsb   <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      addr_lsb   <= pins_i.addr_to_supply;
    end
  end

  assign slave_addr = {ADDR_PREFIX, addr_lsb};

  // serial register bank; a grounded pin wins over any serial write
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NREGS; i++) begin
        bank[i] <= BANK_CLEAR;
      end
    end else if (pins_i.addr_grounded) begin
      for (int i = 0; i < NREGS; i++) begin
        bank[i] <= BANK_CLEAR;
      end
    end else if (ser_wr.wr && 32'(ser_wr.idx) < NREGS) begin
      bank[IDX_W'(ser_wr.idx)] <= ser_wr.data;
    end
  end

  assign ser_rd_data = (32'(ser_ptr) < NREGS) ? bank[IDX_W'(ser_ptr)] : BANK_CLEAR;

  // cleared bit means two phases, so both reset and pin clear give two-phase
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_two_o <= 1'b0;
    end else begin
      phase_two_o <= controller_en_o & ~pins_i.phase_limit_pin
                     & ~bank[PHASE_REG][PHASE_BIT];
    end
  end

  pmac_i2c_slave u_ser (
    .sys_clk_i    (sys_clk_i),
    .rstn_i       (rstn_i),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .sda_o        (sda_o),
    .sda_oe_o     (sda_oe_o),
    .enable_i     (ser_en),
    .slave_addr_i (slave_addr),
    .wr_o         (ser_wr),
    .ptr_o        (ser_ptr),
    .rd_data_i    (ser_rd_data)
  );

  // checks
  enable_follow_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pins_i.en_above ##1 pins_i.en_above |=> controller_en_o)
    else $error("controller not enabled after enable input high");

  disable_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !controller_en_o |=> !phase_two_o)
    else $error("two-phase output while controller disabled");

  table_pick_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !pins_i.tsel_ge_lo |=> table_mode_o == PMAC_TBL_A)
    else $error("low select level did not pick table A");

  table_mid_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pins_i.tsel_ge_lo && !pins_i.tsel_gt_hi |=> table_mode_o == PMAC_TBL_B)
    else $error("middle select level did not pick table B");

  table_high_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pins_i.tsel_ge_lo && pins_i.tsel_gt_hi |=> table_mode_o == PMAC_TBL_C)
    else $error("high select level did not pick table C");

  vid_default_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !voltage_id_driven_i[0] |=> vid_code_o[0] == ($past(table_mode_o) != PMAC_TBL_C))
    else $error("undriven id input read the wrong level");

  single_lock_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pins_i.phase_limit_pin |=> !phase_two_o)
    else $error("two phases while phase-limit pin high");

  bit_steer_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    controller_en_o && !pins_i.phase_limit_pin
      |=> phase_two_o == !$past(bank[PHASE_REG][PHASE_BIT]))
    else $error("phase count does not follow register bit");

  pin_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pins_i.addr_grounded |=> bank[PHASE_REG] == BANK_CLEAR && bank[0] == BANK_CLEAR)
    else $error("grounded pin did not clear serial registers");

  addr_strap_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(strap_done) |-> slave_addr == {ADDR_PREFIX, $past(pins_i.addr_to_supply)})
    else $error("serial address does not match the strap");

  strap_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    strap_done |=> $stable(slave_addr))
    else $error("serial address moved after the strap");

  slave_only_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    ser_wr.wr |-> ser_en && $past(ser_en, 2))
    else $error("serial write while slave disabled");

  bresp_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before ready");

  phase_drop_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    phase_two_o ##1 !phase_two_o && controller_en_o);
  serial_write_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    ser_wr.wr && 32'(ser_wr.idx) == PHASE_REG);
  table_c_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    table_mode_o == PMAC_TBL_C);
  pin_clear_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pins_i.addr_grounded && bank[PHASE_REG] != BANK_CLEAR);
endmodule

`default_nettype wire

// ---- pmac_host_model.sv ----
// two-wire bus host model: makes the serial clock and pulls data low
`timescale 1ns/1ps
`default_nettype none
module pmac_host_model (
  // clock and bus sense
  input  wire logic clk_i,
  input  wire logic sda_i,
  // bus drive, data is open drain
  output logic      scl_o,
  output logic      sda_low_o
);
  logic [8:0] seen = 9'h000;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // half bit of 8 clocks keeps both clock phases well above the minimum
  task automatic half();
    repeat (8) @(posedge clk_i);
  endtask
  // only the host moves the clock; it stands high between frames
  task automatic start();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b0;
    half();
  endtask
  // eight data bits then a released ninth bit for the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_low_o <= (i >= 0) ? ~b[i[2:0]] : 1'b0;
      half();
      scl_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ack = ~sda_i;
      seen = {seen[7:0], sda_i};
      repeat (4) @(posedge clk_i);
      scl_o <= 1'b0;
    end
    half();
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench of the phase, table and address configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmac_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, lvl = 8'h00, drv = 8'h00, lfsr = 8'h23, vid_o;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic scl, host_low, sda_oe, sda_q, en_o, pu, pd, two_o;
  pmac_pins_t pins = 6'h20;
  pmac_table_t mode_o;
  wire sda = ~(host_low | (sda_oe & ~sda_q));
  int bad_count = 0, check_count = 0;
  logic [33:0] exp_q[$];
  always #20 sys_clk = ~sys_clk;
  pmac_config DUT (.sys_clk_i(sys_clk), .rstn_i(rstn), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .pins_i(pins), .voltage_id_level_i(lvl),
    .voltage_id_driven_i(drv), .scl_i(scl), .sda_i(sda), .sda_o(sda_q), .sda_oe_o(sda_oe),
    .controller_en_o(en_o), .table_mode_o(mode_o), .vid_code_o(vid_o),
    .vid_pull_up_o(pu), .vid_pull_down_o(pd), .phase_two_o(two_o));
  pmac_host_model host (.clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // read data and write responses are compared where they appear, against the oldest note
  always @(negedge sys_clk) begin
    if ((rvalid === 1'b1 && rready) || (bvalid === 1'b1 && bready)) begin
      if (exp_q.size() == 0) chk(bvalid ? {bresp, 32'h0} : {rresp, rdata}, 34'h3_dead_beef);
      else chk(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());
    end
  end
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic ah, wh, b;
    @(posedge sys_clk);
    exp_q.push_back({e, 32'h0});
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1; n = 0;
    do begin
      @(negedge sys_clk); ah = awready; wh = wready; b = bvalid;
      @(posedge sys_clk); if (ah) awvalid <= 1'b0; if (wh) wvalid <= 1'b0; n++;
    end while (!b && n < 50);
    bready <= 1'b0;
    if (!b) begin bad_count++; report_and_stop(); end
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    int n;
    logic ah, r;
    @(posedge sys_clk);
    exp_q.push_back(e);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1; n = 0;
    do begin
      @(negedge sys_clk); ah = arready; r = rvalid;
      @(posedge sys_clk); if (ah) arvalid <= 1'b0; n++;
    end while (!r && n < 50);
    rready <= 1'b0;
    if (!r) begin bad_count++; report_and_stop(); end
  endtask
  task automatic ser_wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
    logic ack;
    @(posedge sys_clk);
    host.start();
    host.send(a, ack);
    chk({33'h0, ack}, {33'h0, ok});
    host.send(8'(PHASE_REG), ack);
    chk({33'h0, ack}, {33'h0, ok});
    host.send(d, ack);
    chk({33'h0, ack}, {33'h0, ok});
    host.stop();
  endtask
  // pointer write, then a one-byte read ended by a released ninth bit
  task automatic ser_rd(input logic [7:0] e);
    logic ack;
    @(posedge sys_clk);
    host.start();
    host.send(8'h8c, ack);
    host.send(8'(PHASE_REG), ack);
    host.stop();
    host.start();
    host.send(8'h8d, ack);
    chk({33'h0, ack}, 34'h1);
    host.send(8'hff, ack);
    chk({26'h0, host.seen[8:1]}, {26'h0, e});
    host.stop();
  endtask
  initial begin
    do_reset();
    settle();
    chk({32'h0, en_o, two_o}, 34'h3);
    axr(OFS_CTRL, 34'h1);
    axr(OFS_STATUS, 34'h4607);
    axr(8'h0c, {RESP_DECERR, 32'h0});
    axw(8'h0c, 32'h1, RESP_DECERR);
    for (int t = 0; t < 3; t++) begin
      @(posedge sys_clk);
      lfsr = nx(lfsr); lvl <= lfsr; lfsr = nx(lfsr); drv <= lfsr;
      pins.tsel_ge_lo <= (t > 0); pins.tsel_gt_hi <= (t == 2);
      settle();
      chk({31'h0, mode_o}, 34'(3'b001 << t));
      chk({26'h0, vid_o}, {26'h0, (lvl & drv) | (~drv & {8{t < 2}})});
      chk({32'h0, pu, pd}, {32'h0, t < 2, t == 2});
    end
    @(posedge sys_clk);
    pins.tsel_ge_lo <= 1'b0; pins.tsel_gt_hi <= 1'b0; pins.phase_limit_pin <= 1'b1;
    settle(); chk({33'h0, two_o}, 34'h0);
    ser_wr(8'h8c, 8'h00, 1'b1); settle(); chk({33'h0, two_o}, 34'h0);
    @(posedge sys_clk); pins.phase_limit_pin <= 1'b0;
    settle(); chk({33'h0, two_o}, 34'h1);
    ser_wr(8'h8c, 8'h40, 1'b1); settle(); chk({33'h0, two_o}, 34'h0);
    axr(OFS_BANK + 8'h08, 34'h40);
    ser_rd(8'h40);
    ser_wr(8'h8e, 8'h00, 1'b0);
    axw(OFS_CTRL, 32'h0, RESP_OKAY);
    ser_wr(8'h8c, 8'h00, 1'b0);
    axw(OFS_CTRL, 32'h1, RESP_OKAY);
    axr(OFS_BANK + 8'h08, 34'h40);
    // pin is only ever pulled low here, as an open-drain reset would
    @(posedge sys_clk); pins.addr_grounded <= 1'b1;
    settle(); @(posedge sys_clk); pins.addr_grounded <= 1'b0;
    settle(); chk({33'h0, two_o}, 34'h1);
    axr(OFS_BANK + 8'h08, 34'h0);
    @(posedge sys_clk); pins.en_above <= 1'b0;
    settle(); chk({32'h0, en_o, two_o}, 34'h0);
    @(posedge sys_clk); pins.en_above <= 1'b1; pins.addr_to_supply <= 1'b1;
    do_reset(); settle();
    axr(OFS_STATUS, 34'h4707);
    ser_wr(8'h8e, 8'h00, 1'b1);
    ser_wr(8'h8c, 8'h00, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
